/* verilog/pds_regs.sv */
/*
  Loop divider and sync configuration bank with AHB-Lite slave.
  Assumes ref_clk is the sample clock; loop status and sync pins are
  asynchronous; buf_rst_tick comes from logic on ref_clk.
*/
// Decided for this implementation: the AHB-Lite slave port.
// Contract
// - controller clock divider code 0..3 divides sample clock by 2,4,8,16
// - oscillator divider code gives ratio 1,2,4,4; default 10
// - loop divider code gives ratio 2,4,8,16; default 01
// - lock status bit 7 reads 1 while loop tracks reference
// - lock status bits 3:0 read oscillator control voltage
// - band readback bits 5:0 show oscillator band in use
// - sync control bit 7 enables sync logic, reset 0
// - bit 6 picks buffer reset rate (0) or data rate (1), default 1
// - bit 3 picks falling (0) or rising (1) sync edge, default 1
// - averaging code n averages 2 to the n phase samples
// - phase request 0..63 sample cycles, default 0
// - requested offset shifts output timing relative to sync input
// - averaged phase readable in 6.2 format
// - sync locked flag, and latched sync lost flag
`timescale 1ns/1ns
`include "pds_cfg.svh"
module pds_regs (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // AHB-Lite slave
  input  wire pds_pkg::pds_ahb_req_t ahb_req,
  output      pds_pkg::pds_ahb_rsp_t ahb_rsp,
  // Analog loop status and sync pins
  input  wire pds_pkg::pds_pll_stat_t pll_stat,
  input  wire logic                  sync_in,
  input  wire logic                  buf_rst_tick,
  // Divider controls
  output      logic                  ctl_clk_en,
  output      logic [4:0]            ctl_ratio,
  output      logic [2:0]            osc_ratio,
  output      logic [4:0]            loop_ratio,
  // Aligned output timing
  output      logic                  sync_frame
);
  import pds_pkg::*;

  function automatic logic [4:0] pow2_ratio(input logic [1:0] c);
    pow2_ratio = 5'h02 << c;
  endfunction
  function automatic logic [2:0] osc_ratio_f(input logic [1:0] c);
    osc_ratio_f = (c == 2'h0) ? 3'h1 : (c == 2'h1) ? 3'h2 : 3'h4;
  endfunction

  logic [7:0]    div_q, div_d, sctl_q, sctl_d, rd_q, rd_d;
  logic [7:0]    nav_q, nav_d, avg_q, avg_d, samp_n;
  logic [5:0]    preq_q, preq_d, idx_q, idx_d, ph_q, ph_d, samp;
  logic [10:0]   ps1_q, ps2_q, ps3_q, pst_q, pst_d;
  logic          sy1_q, sy2_q, sy3_q, lvl_q, lvl_d;
  logic          wr_q, wr_d, cen_q, cen_d, frm_q, frm_d, lost_q, lost_d;
  logic [3:0]    cdiv_q, cdiv_d;
  logic [12:0]   sum_q, sum_d;
  logic [14:0]   sum4;
  pds_sy_st_t    st_q, st_d;
  logic          ap, wr_div, edge_ok, acc, clr_lost, win_end;
  pds_pll_stat_t pst;

  // Address phase and register write strobe
  assign ap     = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
  assign wr_div = wr_q && (idx_q == `PDS_IDX_DIV);
  assign clr_lost = wr_q && (idx_q == `PDS_IDX_SSTAT)
                    && ahb_req.hwdata[`PDS_B_SLOST];
  assign pst    = pds_pll_stat_t'(pst_q);

  // Bus pipeline and register writes
  always_comb
  begin
    wr_d   = ap && ahb_req.hwrite && (ahb_req.haddr[31:8] == 24'h0);
    idx_d  = ahb_req.haddr[7:2];
    div_d  = div_q;
    sctl_d = sctl_q;
    preq_d = preq_q;
    rd_d   = rd_q;
    if (wr_q)
    begin
      case (idx_q)
        `PDS_IDX_DIV:  div_d  = ahb_req.hwdata[7:0];
        `PDS_IDX_SCTL: sctl_d = ahb_req.hwdata[7:0];
        `PDS_IDX_PREQ: preq_d = ahb_req.hwdata[5:0];
        default:       preq_d = preq_q;
      endcase
    end
    if (ap && !ahb_req.hwrite)
    begin
      if (ahb_req.haddr[31:8] != 24'h0)
        rd_d = 8'h00;
      else
      begin
        case (ahb_req.haddr[7:2])
          `PDS_IDX_DIV:   rd_d = div_d;   // Sees a pending write
          `PDS_IDX_LOCK:  rd_d = {pst.locked, 3'h0, pst.vco_volt};
          `PDS_IDX_BAND:  rd_d = {2'h0, pst.band};
          `PDS_IDX_SCTL:  rd_d = sctl_d;
          `PDS_IDX_PREQ:  rd_d = {2'h0, preq_d};
          `PDS_IDX_SSTAT: rd_d = {lost_q, st_q == SY_LOCK, 6'h00};
          `PDS_IDX_PHRB:  rd_d = avg_q;
          default:        rd_d = 8'h00;
        endcase
      end
    end
  end

  // Reset restores documented defaults
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_q  <= `PDS_DIV_RST;
      sctl_q <= `PDS_SCTL_RST;
      preq_q <= `PDS_PREQ_RST;
      wr_q   <= 1'b0;
      idx_q  <= 6'h00;
      rd_q   <= 8'h00;
    end
    else
    begin
      div_q  <= div_d;
      sctl_q <= sctl_d;
      preq_q <= preq_d;
      wr_q   <= wr_d;
      idx_q  <= idx_d;
      rd_q   <= rd_d;
    end
  end

  // Zero wait state slave, always OKAY
  assign ahb_rsp.hrdata    = {24'h000000, rd_q};
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp     = 1'b0;
  // Pin synchronisers; a change counts once stages two and three agree
  always_comb
  begin
    pst_d = (ps2_q & ~(ps2_q ^ ps3_q)) | (pst_q & (ps2_q ^ ps3_q));
    lvl_d = (sy2_q == sy3_q) ? sy3_q : lvl_q;
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ps1_q <= 11'h000;
      ps2_q <= 11'h000;
      ps3_q <= 11'h000;
      pst_q <= 11'h000;
      sy1_q <= 1'b0;
      sy2_q <= 1'b0;
      sy3_q <= 1'b0;
      lvl_q <= 1'b0;
    end
    else
    begin
      ps1_q <= pll_stat;
      ps2_q <= ps1_q;
      ps3_q <= ps2_q;
      pst_q <= pst_d;
      sy1_q <= sync_in;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      lvl_q <= lvl_d;
    end
  end

  // Controller clock enable divider, restarted on divider write
  always_comb
  begin
    cdiv_d = cdiv_q + 4'h1;
    cen_d  = 1'b0;
    if (wr_div)
      cdiv_d = 4'h0;
    else if (cdiv_q == 4'(pow2_ratio(div_q[7:6]) - 5'h01))
    begin
      cdiv_d = 4'h0;
      cen_d  = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cdiv_q <= 4'h0;
      cen_q  <= 1'b0;
    end
    else
    begin
      cdiv_q <= cdiv_d;
      cen_q  <= cen_d;
    end
  end

  assign ctl_clk_en = cen_q;
  assign ctl_ratio  = pow2_ratio(div_q[7:6]);
  assign osc_ratio  = osc_ratio_f(div_q[3:2]);
  assign loop_ratio = pow2_ratio(div_q[1:0]);

  // Accepted sync edge: polarity, enable and rate gate
  assign edge_ok = sctl_q[`PDS_B_EDGE] ? (lvl_d && !lvl_q)
                                       : (!lvl_d && lvl_q);
  assign acc     = edge_ok && sctl_q[`PDS_B_SYNC_EN]
                   && (sctl_q[`PDS_B_RATE] || buf_rst_tick);
  assign samp    = `PDS_PH_MAX - ph_q - 6'h01;  // Equals request if no reload
  assign samp_n  = 8'h01 << sctl_q[2:0];
  assign win_end = acc && (nav_q + 8'h01 == samp_n);
  assign sum4    = {sum_q + {7'h00, samp}, 2'b00};

  // Phase counter, averaging and sync state
  always_comb
  begin
    ph_d   = ph_q + 6'h01;
    sum_d  = sum_q;
    nav_d  = nav_q;
    avg_d  = avg_q;
    st_d   = st_q;
    lost_d = lost_q && !clr_lost;
    if (acc)
    begin
      ph_d  = `PDS_PH_MAX - preq_q;
      sum_d = sum_q + {7'h00, samp};
      nav_d = nav_q + 8'h01;
    end
    frm_d = (ph_d == `PDS_PH_MAX);
    if (win_end)
    begin
      avg_d = 8'(sum4 >> sctl_q[2:0]);
      sum_d = 13'h0000;
      nav_d = 8'h00;
    end
    case (st_q)
      SY_OFF:
        if (sctl_q[`PDS_B_SYNC_EN])
          st_d = SY_ACQ;
      SY_ACQ:
        if (win_end && avg_d == {preq_q, 2'b00})
          st_d = SY_LOCK;
      SY_LOCK:
        if (win_end && avg_d != {preq_q, 2'b00})
        begin
          st_d   = SY_ACQ;
          lost_d = 1'b1;
        end
      default:
        st_d = SY_OFF;
    endcase
    if (!sctl_q[`PDS_B_SYNC_EN])
    begin
      st_d  = SY_OFF;
      sum_d = 13'h0000;
      nav_d = 8'h00;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ph_q   <= 6'h00;
      frm_q  <= 1'b0;
      sum_q  <= 13'h0000;
      nav_q  <= 8'h00;
      avg_q  <= 8'h00;
      lost_q <= 1'b0;
      st_q   <= SY_OFF;
    end
    else
    begin
      ph_q   <= ph_d;
      frm_q  <= frm_d;
      sum_q  <= sum_d;
      nav_q  <= nav_d;
      avg_q  <= avg_d;
      lost_q <= lost_d;
      st_q   <= st_d;
    end
  end

  assign sync_frame = frm_q;
  // Checking helpers: cycles since last enable pulse
  logic [4:0] gap_q;
  logic       seen_q;
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gap_q  <= 5'h00;
      seen_q <= 1'b0;
    end
    else
    begin
      gap_q  <= (cen_q || wr_div) ? 5'h00 : gap_q + 5'h01;
      seen_q <= (seen_q || cen_q) && !wr_div;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  AST_CTL_DIV: assert property (
    cen_q && seen_q |-> gap_q == pow2_ratio(div_q[7:6]) - 5'h01)
    else $error("controller clock enable spacing wrong");
  AST_OSC_DIV: assert property (
    div_q[3] |-> osc_ratio == 3'h4)
    else $error("oscillator ratio not 4 for codes 10 and 11");
  AST_LOOP_DIV: assert property (
    div_q[1:0] == 2'h3 |-> loop_ratio == 5'h10)
    else $error("loop ratio not 16 for code 11");
  AST_LOCK_RD: assert property (
    ap && !ahb_req.hwrite && ahb_req.haddr == 32'h00000038
    |=> ahb_rsp.hrdata[7] == $past(pst_q[10]))
    else $error("lock flag readback mismatch");
  AST_BAND_RD: assert property (
    ap && !ahb_req.hwrite && ahb_req.haddr == 32'h0000003C
    |=> ahb_rsp.hrdata == {26'h0, $past(pst_q[5:0])})
    else $error("band readback mismatch");
  AST_SYNC_OFF: assert property (
    !sctl_q[`PDS_B_SYNC_EN] |-> !acc ##1 st_q == SY_OFF)
    else $error("sync active while disabled");
  AST_EDGE_POL: assert property (
    acc |-> lvl_d == sctl_q[`PDS_B_EDGE])
    else $error("sync taken on wrong edge");
  AST_FRAME: assert property (
    acc && preq_q == 6'h00 |=> sync_frame ##1 !sync_frame)
    else $error("zero offset frame not next cycle");
  AST_LOST: assert property (
    lost_q && !clr_lost |=> lost_q)
    else $error("sync lost flag not latched");
  AST_DFLT: assert property (
    $rose(reset_n) |-> div_q == `PDS_DIV_RST && sctl_q == `PDS_SCTL_RST
                       && preq_q == `PDS_PREQ_RST)
    else $error("writable field not at default after reset");
  COV_LOCK: cover property (st_q == SY_ACQ ##1 st_q == SY_LOCK);
  COV_LOST: cover property (!lost_q ##1 lost_q);
  COV_CLR:  cover property (lost_q ##1 clr_lost ##1 !lost_q);
endmodule // pds_regs

/* verilog/pds_cfg.svh */
/*
  Register indices, reset values, bit positions and limits for the
  loop divider and sync configuration bank.
  Assumes byte address = index * 4 on a 32-bit AHB-Lite bus.
*/
`ifndef PDS_CFG_SVH
`define PDS_CFG_SVH
// Register indices
`define PDS_IDX_DIV   6'h0D
`define PDS_IDX_LOCK  6'h0E
`define PDS_IDX_BAND  6'h0F
`define PDS_IDX_SCTL  6'h10
`define PDS_IDX_PREQ  6'h11
`define PDS_IDX_SSTAT 6'h12
`define PDS_IDX_PHRB  6'h13
// Reset values
`define PDS_DIV_RST   8'hC9
`define PDS_SCTL_RST  8'h48
`define PDS_PREQ_RST  6'h00
// Bit positions
`define PDS_B_SYNC_EN 3'h7
`define PDS_B_RATE    3'h6
`define PDS_B_EDGE    3'h3
`define PDS_B_PLOCK   3'h7
`define PDS_B_SLOST   3'h7
`define PDS_B_SLOCK   3'h6
// Phase counter top
`define PDS_PH_MAX    6'h3F
`endif

/* verilog/pds_pkg.sv */
/*
  Types for the loop divider and sync configuration bank.
  Assumes an AHB-Lite master with single word transfers.
*/
package pds_pkg;
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } pds_ahb_req_t;
  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } pds_ahb_rsp_t;
  typedef struct packed {
    logic       locked;
    logic [3:0] vco_volt;
    logic [5:0] band;
  } pds_pll_stat_t;
  typedef enum logic [1:0] {SY_OFF, SY_ACQ, SY_LOCK} pds_sy_st_t;
endpackage

/* dv/pds_regs_tb_top.sv */
/*
  Self-checking bench for the loop divider and sync configuration bank.
  Assumes pds_pkg is compiled first and the bank answers at once.
*/
`timescale 1ns/1ns
module pds_regs_tb_top;
  import pds_pkg::*;
  logic          ref_clk;
  logic          reset_n;
  logic          hsel;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [31:0]   hwdata;
  pds_ahb_req_t  ahb_req;
  pds_ahb_rsp_t  ahb_rsp;
  pds_pll_stat_t pll_stat;
  logic          sync_in;
  logic          buf_rst_tick;
  logic          ctl_clk_en;
  logic [4:0]    ctl_ratio;
  logic [2:0]    osc_ratio;
  logic [4:0]    loop_ratio;
  logic          sync_frame;
  logic [31:0]   rd;
  int            num_errors;
  int            total_checks;
  int            sync_per;
  int            cyc;
  int            n;
  int            d5;
  int            d;

  // Slave ready feeds straight back as bus ready
  assign ahb_req = '{hsel, haddr, htrans, hwrite, 3'h2, hwdata,
                     ahb_rsp.hreadyout};

  pds_regs i_dut (
    .ref_clk      (ref_clk),
    .reset_n      (reset_n),
    .ahb_req      (ahb_req),
    .ahb_rsp      (ahb_rsp),
    .pll_stat     (pll_stat),
    .sync_in      (sync_in),
    .buf_rst_tick (buf_rst_tick),
    .ctl_clk_en   (ctl_clk_en),
    .ctl_ratio    (ctl_ratio),
    .osc_ratio    (osc_ratio),
    .loop_ratio   (loop_ratio),
    .sync_frame   (sync_frame)
  );

  // Sample clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Sync pin: high for 8 cycles every sync_per cycles
  always @(posedge ref_clk)
  begin
    if (sync_per != 0)
    begin
      cyc <= (cyc + 1 >= sync_per) ? 0 : cyc + 1;
      sync_in <= (cyc < 8);
    end
  end

  // One AHB-Lite single word transfer
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (ahb_rsp.hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (ahb_rsp.hreadyout !== 1'b1);
    rd = ahb_rsp.hrdata;
  endtask

  task automatic chk_reg(input string s, input logic [31:0] e,
                         input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic chk_cnt(input string s, input int e, input int g);
    total_checks++;
    if (g != e)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %0d got %0d", s, e, g);
    end
  endtask

  task automatic rchk(input string s, input logic [7:0] a,
                      input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk_reg(s, e, rd);
    chk_reg("hresp", 32'h0, {31'h0, ahb_rsp.hresp});
  endtask

  // Cycles from a sync pin rise to the next aligned frame pulse
  task automatic meas(output int dl);
    dl = 0;
    @(posedge sync_in);
    do
    begin
      @(posedge ref_clk);
      #1;
      dl++;
    end
    while (sync_frame !== 1'b1 && dl < 200);
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    num_errors++;
    close_out();
  end

  // Test sequence
  initial
  begin
    reset_n = 1'b0;
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    pll_stat = '0;
    sync_in = 1'b0;
    buf_rst_tick = 1'b0;
    {sync_per, cyc, num_errors, total_checks} = '0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    rchk("div_rst", 8'h34, 32'hC9);
    rchk("sctl_rst", 8'h40, 32'h48);
    rchk("preq_rst", 8'h44, 32'h00);
    rchk("unmapped", 8'h00, 32'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'h34, {24'h0, 2'(i), 2'b00, 2'(i), 2'(i)});
      n = 0;
      repeat (32)
      begin
        @(posedge ref_clk);
        #1;
        n += ctl_clk_en;
      end
      chk_cnt("ctl_pulses", 32 >> (i + 1), n);
      chk_reg("ctl_ratio", 2 << i, ctl_ratio);
      chk_reg("osc_ratio", (i == 0) ? 1 : (i == 1) ? 2 : 4,
              osc_ratio);
      chk_reg("loop_ratio", 2 << i, loop_ratio);
    end
    $display("test dividers done");
    pll_stat <= '{1'b1, 4'hA, 6'h2B};
    repeat (8) @(posedge ref_clk);
    bus(1'b1, 8'h38, 32'h00);
    rchk("lock_stat", 8'h38, 32'h8A);
    rchk("band", 8'h3C, 32'h2B);
    pll_stat <= '{1'b0, 4'h5, 6'h11};
    repeat (8) @(posedge ref_clk);
    rchk("lock_live", 8'h38, 32'h05);
    rchk("band_live", 8'h3C, 32'h11);
    $display("test status done");
    bus(1'b1, 8'h44, 32'hFF);
    rchk("preq_max", 8'h44, 32'h3F);
    bus(1'b1, 8'h44, 32'h05);
    bus(1'b1, 8'h40, 32'hCA);
    sync_per = 64;
    repeat (640) @(posedge ref_clk);
    rchk("sy_locked", 8'h48, 32'h40);
    rchk("sy_phase", 8'h4C, 32'h14);
    meas(d5);
    bus(1'b1, 8'h44, 32'h0A);
    repeat (640) @(posedge ref_clk);
    meas(d);
    chk_cnt("shift", 5, d - d5);
    rchk("sy_lost", 8'h48, 32'hC0);
    rchk("sy_phase2", 8'h4C, 32'h28);
    bus(1'b1, 8'h40, 32'h48);
    bus(1'b1, 8'h48, 32'h80);
    rchk("sy_clear", 8'h48, 32'h00);
    $display("test sync done");
    bus(1'b1, 8'h44, 32'h05);
    bus(1'b1, 8'h40, 32'hC0);
    repeat (640) @(posedge ref_clk);
    meas(d);
    chk_cnt("fall_edge", 8, d - d5);
    $display("test edge done");
    // Buffer reset rate: no tick keeps the old alignment, ticks realign
    bus(1'b1, 8'h40, 32'h80);
    bus(1'b1, 8'h44, 32'h0A);
    repeat (200) @(posedge ref_clk);
    meas(d);
    chk_cnt("rate_gate", 8, d - d5);
    buf_rst_tick <= 1'b1;
    repeat (200) @(posedge ref_clk);
    meas(d);
    chk_cnt("rate_tick", 13, d - d5);
    $display("test rate done");
    close_out();
  end
endmodule // pds_regs_tb_top
